/* File: boot_reset_clock_defaults.sv */
// Boot reset sequencer and clock defaults, running on the RC oscillator clock.
// Assumes i_pwr_good comes from an analog detector and is asynchronous here;
// software settings arrive from a same-clock configuration source.
`timescale 1ns/1ps
`default_nettype none
`include "boot_reset_consts.svh"
module boot_reset_clock_defaults
   import boot_reset_pkg::*;
#(
   parameter int N_PLL = 2,
   parameter int N_MOD = 8
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   input wire logic i_pwr_good,
   input wire logic i_sw_cfg_we,
   input wire logic [N_PLL-1:0] i_sw_pll_en,
   input wire logic [1:0] i_sw_clk_src,
   input wire logic [N_MOD-1:0] i_sw_clk_en,
   input wire logic [4*N_MOD-1:0] i_sw_clk_div,
   output logic o_sys_rst_b,
   output logic o_fetch_start,
   output logic [31:0] o_fetch_addr,
   output logic o_fetch_in_flash,
   output logic [1:0] o_clk_src,
   output logic [N_PLL-1:0] o_pll_en,
   output logic [N_MOD-1:0] o_clk_en,
   output logic [4*N_MOD-1:0] o_clk_div
);
   logic pwr_good_s;
   boot_state_t state_r;
   boot_state_t state_nxt;
   logic [3:0] hold_cnt_r;
   logic [3:0] hold_cnt_nxt;
   logic sys_rst_b_r;
   logic sys_rst_b_nxt;
   logic fetch_start_r;
   logic fetch_start_nxt;
   logic [31:0] fetch_addr_r;
   logic [31:0] fetch_addr_nxt;
   logic fetch_in_flash_r;
   logic fetch_in_flash_nxt;
   logic [1:0] clk_src_r;
   logic [1:0] clk_src_nxt;
   logic [N_PLL-1:0] pll_en_r;
   logic [N_PLL-1:0] pll_en_nxt;
   logic [N_MOD-1:0] clk_en_r;
   logic [N_MOD-1:0] clk_en_nxt;
   logic [4*N_MOD-1:0] clk_div_r;
   logic [4*N_MOD-1:0] clk_div_nxt;

   // Power-good is an analog level; never read it before two flops
   sync_2ff u_pg_sync (
      .i_ref_clk(i_ref_clk),
      .i_rst_b(i_rst_b),
      .i_async(i_pwr_good),
      .o_sync(pwr_good_s)
   );

   // Sequencer: a dip in power-good always returns to hold
   always_comb begin
      state_nxt = state_r;
      hold_cnt_nxt = hold_cnt_r;
      sys_rst_b_nxt = 1'b0;
      fetch_start_nxt = 1'b0;
      if (!pwr_good_s) begin
         state_nxt = ST_HOLD;
         hold_cnt_nxt = 4'h0;
      end else begin
         unique case (state_r)
            ST_HOLD: begin
               state_nxt = ST_RELEASE;
               hold_cnt_nxt = 4'h0;
            end
            ST_RELEASE: begin
               // Short settle so defaults are stable before reset lifts
               hold_cnt_nxt = hold_cnt_r + 4'h1;
               if (hold_cnt_r == `RELEASE_HOLD_CYCLES - 4'h1) begin
                  state_nxt = ST_RUN;
                  sys_rst_b_nxt = 1'b1;
                  fetch_start_nxt = 1'b1;
               end
            end
            ST_RUN: begin
               sys_rst_b_nxt = 1'b1;
            end
            // The unused state code falls back to hold rather than locking up
            default: begin
               state_nxt = ST_HOLD;
               hold_cnt_nxt = 4'h0;
            end
         endcase
      end
   end

   // Clock configuration: defaults forced outside run, software-owned in run
   always_comb begin
      clk_src_nxt = clk_src_r;
      pll_en_nxt = pll_en_r;
      clk_en_nxt = clk_en_r;
      clk_div_nxt = clk_div_r;
      fetch_addr_nxt = `RESET_VECTOR_ADDR;
      fetch_in_flash_nxt = ((`RESET_VECTOR_ADDR & `FLASH_REGION_MASK) == `FLASH_BASE_ADDR);
      // Defaults return on the same edge that drops the system reset, so no
      // software PLL or gate setting survives into a reset period
      if (!pwr_good_s || state_r != ST_RUN) begin
         clk_src_nxt = `CLK_SRC_RC;
         pll_en_nxt = '0;
         clk_en_nxt = '1;
         clk_div_nxt = {N_MOD{`DIV_PASS}};
      end else if (i_sw_cfg_we) begin
         clk_src_nxt = i_sw_clk_src;
         pll_en_nxt = i_sw_pll_en;
         clk_en_nxt = i_sw_clk_en;
         clk_div_nxt = i_sw_clk_div;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_r <= ST_HOLD;
         hold_cnt_r <= 4'h0;
         sys_rst_b_r <= 1'b0;
         fetch_start_r <= 1'b0;
         fetch_addr_r <= `RESET_VECTOR_ADDR;
         fetch_in_flash_r <= 1'b1;
         clk_src_r <= `CLK_SRC_RC;
         pll_en_r <= '0;
         clk_en_r <= '1;
         clk_div_r <= '0;
      end else begin
         state_r <= state_nxt;
         hold_cnt_r <= hold_cnt_nxt;
         sys_rst_b_r <= sys_rst_b_nxt;
         fetch_start_r <= fetch_start_nxt;
         fetch_addr_r <= fetch_addr_nxt;
         fetch_in_flash_r <= fetch_in_flash_nxt;
         clk_src_r <= clk_src_nxt;
         pll_en_r <= pll_en_nxt;
         clk_en_r <= clk_en_nxt;
         clk_div_r <= clk_div_nxt;
      end
   end

   assign o_sys_rst_b = sys_rst_b_r;
   assign o_fetch_start = fetch_start_r;
   assign o_fetch_addr = fetch_addr_r;
   assign o_fetch_in_flash = fetch_in_flash_r;
   assign o_clk_src = clk_src_r;
   assign o_pll_en = pll_en_r;
   assign o_clk_en = clk_en_r;
   assign o_clk_div = clk_div_r;

   // Checks
   sequence s_release;
      $rose(o_sys_rst_b);
   endsequence

   // Synchronised supply seen good across the whole hold and settle span
   sequence s_supply_up;
      $rose(pwr_good_s) ##1 pwr_good_s [*4];
   endsequence

   a_reset_while_low: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      !pwr_good_s |=> !o_sys_rst_b)
      else $error("system reset not held while supply unstable");

   a_hold_in_reset: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      state_r != ST_RUN |-> !o_sys_rst_b)
      else $error("system reset released outside run state");

   a_release_time: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      $rose(pwr_good_s) ##1 pwr_good_s [*5] |-> o_sys_rst_b)
      else $error("reset not released after settle time");

   // Exact edge: an early release would let the CPU run on unsettled defaults
   a_release_exact: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      s_supply_up |-> !o_sys_rst_b ##1 o_sys_rst_b)
      else $error("reset release not on the settle edge");

   a_run_released: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      (state_r == ST_RUN && pwr_good_s) |=> o_sys_rst_b)
      else $error("system reset dropped while supply good");

   a_src_rc_boot: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      s_release |-> o_clk_src == `CLK_SRC_RC)
      else $error("clock source not RC at release");

   a_pll_off_boot: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      !o_sys_rst_b |-> o_pll_en == '0)
      else $error("PLL enabled during reset");

   a_dip_defaults: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      !pwr_good_s |=> o_clk_src == `CLK_SRC_RC && o_pll_en == '0 && &o_clk_en
         && o_clk_div == {N_MOD{`DIV_PASS}})
      else $error("clock defaults not restored on supply loss");

   a_clk_all_on: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      s_release |-> &o_clk_en)
      else $error("module clock gated at release");

   a_div_pass: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      s_release |-> o_clk_div == '0)
      else $error("divider not pass-through at release");

   a_fetch_vector: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      s_release |-> o_fetch_start && o_fetch_addr == 32'h8000_0000 && o_fetch_in_flash)
      else $error("fetch not started at reset vector in flash");

   a_fetch_once: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      o_fetch_start |=> !o_fetch_start)
      else $error("fetch start longer than one cycle");

   a_fetch_at_release: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      o_fetch_start |-> o_sys_rst_b && !$past(o_sys_rst_b))
      else $error("fetch start away from reset release");

   a_sw_update: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      (state_r == ST_RUN && pwr_good_s && i_sw_cfg_we) |=> o_pll_en == $past(i_sw_pll_en))
      else $error("software PLL setting not applied");

   a_cfg_steady: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      (state_r == ST_RUN && pwr_good_s && !i_sw_cfg_we) |=> $stable(o_clk_src)
         && $stable(o_pll_en) && $stable(o_clk_en) && $stable(o_clk_div))
      else $error("clock setting changed without a software write");
endmodule
`default_nettype wire

/* File: boot_reset_consts.svh */
// Constants for the boot reset and clock default block.
// Included by the design module and the testbench; definitions only.
`ifndef BOOT_RESET_CONSTS_SVH
`define BOOT_RESET_CONSTS_SVH

`define RESET_VECTOR_ADDR 32'h8000_0000
`define FLASH_BASE_ADDR 32'h8000_0000
`define FLASH_REGION_MASK 32'hFF00_0000
`define CLK_SRC_RC 2'h0
`define CLK_SRC_OSC 2'h1
`define CLK_SRC_PLL0 2'h2
`define CLK_SRC_PLL1 2'h3
`define DIV_PASS 4'h0
`define RELEASE_HOLD_CYCLES 4'h4
`define CFG_FLAGS_RESET 8'h00

`endif

/* File: boot_reset_pkg.sv */
// Types shared by the boot reset and clock default block.
// Constants live in boot_reset_consts.svh.
package boot_reset_pkg;
   typedef enum logic [1:0] {
      ST_HOLD,
      ST_RELEASE,
      ST_RUN
   } boot_state_t;
endpackage

/* File: sync_2ff.sv */
// Two-flop level synchroniser into the reference clock domain.
// Assumes the input is a slow level from outside this clock's domain.
`timescale 1ns/1ps
`default_nettype none
module sync_2ff (
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   input wire logic i_async,
   output logic o_sync
);
   logic meta_r;
   logic meta_nxt;
   logic sync_r;
   logic sync_nxt;

   always_comb begin
      meta_nxt = i_async;
      sync_nxt = meta_r;
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign o_sync = sync_r;
endmodule
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the boot reset and clock default block.
// Assumes a single 200 MHz reference clock and the design's own defaults header.
`timescale 1ns/1ps
`default_nettype none
`include "boot_reset_consts.svh"
module tb;
   import boot_reset_pkg::*;
   logic i_ref_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic i_pwr_good = 1'b0;
   logic i_sw_cfg_we = 1'b0;
   logic [1:0] i_sw_pll_en = 2'h0;
   logic [1:0] i_sw_clk_src = 2'h0;
   logic [7:0] i_sw_clk_en = 8'h00;
   logic [31:0] i_sw_clk_div = 32'h0000_0000;
   logic o_sys_rst_b, o_fetch_start, o_fetch_in_flash;
   logic [31:0] o_fetch_addr, o_clk_div;
   logic [1:0] o_clk_src, o_pll_en;
   logic [7:0] o_clk_en;
   logic [63:0] exp_prev;
   int fails = 0;
   int n_compared = 0;
   int n;
   always #2.5 i_ref_clk = ~i_ref_clk;
   boot_reset_clock_defaults #(.N_PLL(2), .N_MOD(8)) i_dut (.i_ref_clk(i_ref_clk),
      .i_rst_b(i_rst_b), .i_pwr_good(i_pwr_good), .i_sw_cfg_we(i_sw_cfg_we),
      .i_sw_pll_en(i_sw_pll_en), .i_sw_clk_src(i_sw_clk_src), .i_sw_clk_en(i_sw_clk_en),
      .i_sw_clk_div(i_sw_clk_div), .o_sys_rst_b(o_sys_rst_b), .o_fetch_start(o_fetch_start),
      .o_fetch_addr(o_fetch_addr), .o_fetch_in_flash(o_fetch_in_flash), .o_clk_src(o_clk_src),
      .o_pll_en(o_pll_en), .o_clk_en(o_clk_en), .o_clk_div(o_clk_div));
   function automatic logic [63:0] cfg(logic [1:0] s, logic [1:0] p, logic [7:0] e,
      logic [31:0] d);
      return {20'h0_0000, s, p, e, d};
   endfunction
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic chk_defaults(input logic rst_exp);
      chk("sys_rst_b", rst_exp, o_sys_rst_b);
      chk("fetch_addr", `RESET_VECTOR_ADDR, o_fetch_addr);
      chk("fetch_in_flash", 1'b1, o_fetch_in_flash);
      chk("clk_cfg", cfg(`CLK_SRC_RC, 2'h0, 8'hFF, {8{`DIV_PASS}}),
         cfg(o_clk_src, o_pll_en, o_clk_en, o_clk_div));
   endtask
   // Counts edges from the driving edge until the system reset reaches the wanted level
   task automatic edges_until(input logic want, output int cnt);
      cnt = 0;
      repeat (40) begin
         @(posedge i_ref_clk);
         #1;
         cnt++;
         if (o_sys_rst_b === want) return;
      end
      fails++;
      $display("FAIL sys_rst_b wait expected %b seen %b", want, o_sys_rst_b);
      stop_test();
   endtask
   task automatic power_up;
      @(posedge i_ref_clk);
      i_pwr_good <= 1'b1;
      edges_until(1'b1, n);
      chk("release_latency", 7, n);
      chk("fetch_start", 1'b1, o_fetch_start);
      chk_defaults(1'b1);
      @(posedge i_ref_clk);
      #1;
      chk("fetch_start_pulse", 1'b0, o_fetch_start);
   endtask
   initial begin
      void'($urandom(95841));
      repeat (2) @(posedge i_ref_clk);
      i_rst_b <= 1'b1;
      #1;
      chk_defaults(1'b0);
      // A write while held in reset must leave the defaults untouched
      @(posedge i_ref_clk);
      {i_sw_cfg_we, i_sw_pll_en, i_sw_clk_src, i_sw_clk_en} <= {1'b1, 2'h3, 2'h2, 8'h00};
      i_sw_clk_div <= 32'hFFFF_FFFF;
      @(posedge i_ref_clk);
      i_sw_cfg_we <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
      #1;
      chk_defaults(1'b0);
      $display("test reset defaults done");
      power_up();
      $display("test power up done");
      // Back-to-back writes: each source code, corner values first, then random
      for (int i = 0; i < 13; i++) begin
         @(posedge i_ref_clk);
         if (i < 12) begin
            i_sw_cfg_we <= 1'b1;
            i_sw_clk_src <= 2'(i % 4);
            i_sw_pll_en <= (i == 0) ? 2'h3 : 2'($urandom());
            i_sw_clk_en <= (i == 1) ? 8'h00 : 8'($urandom());
            i_sw_clk_div <= (i == 0) ? 32'hFFFF_FFFF : $urandom();
         end else i_sw_cfg_we <= 1'b0;
         #1;
         if (i > 0) chk("sw_cfg", exp_prev, cfg(o_clk_src, o_pll_en, o_clk_en, o_clk_div));
         exp_prev = cfg(i_sw_clk_src, i_sw_pll_en, i_sw_clk_en, i_sw_clk_div);
      end
      // Inputs moving without the strobe must not reach the outputs
      @(posedge i_ref_clk);
      i_sw_pll_en <= ~i_sw_pll_en;
      i_sw_clk_en <= ~i_sw_clk_en;
      i_sw_clk_src <= ~i_sw_clk_src;
      repeat (2) @(posedge i_ref_clk);
      #1;
      chk("sw_hold", exp_prev, cfg(o_clk_src, o_pll_en, o_clk_en, o_clk_div));
      $display("test software config done");
      @(posedge i_ref_clk);
      i_pwr_good <= 1'b0;
      edges_until(1'b0, n);
      chk("dip_latency", 3, n);
      chk_defaults(1'b0);
      power_up();
      $display("test power dip done");
      // Leave a software setting in place so the reset has something to undo
      @(posedge i_ref_clk);
      {i_sw_cfg_we, i_sw_pll_en, i_sw_clk_src, i_sw_clk_en} <= {1'b1, 2'h3, 2'h2, 8'h0F};
      @(posedge i_ref_clk);
      i_sw_cfg_we <= 1'b0;
      #1;
      chk("pre_reset_cfg", cfg(2'h2, 2'h3, 8'h0F, i_sw_clk_div),
         cfg(o_clk_src, o_pll_en, o_clk_en, o_clk_div));
      @(posedge i_ref_clk);
      i_rst_b <= 1'b0;
      #1;
      chk_defaults(1'b0);
      @(posedge i_ref_clk);
      i_rst_b <= 1'b1;
      edges_until(1'b1, n);
      chk("rst_release_latency", 7, n);
      chk("fetch_start_rst", 1'b1, o_fetch_start);
      chk_defaults(1'b1);
      $display("test mid-run reset done");
      stop_test();
   end
endmodule
`default_nettype wire
